// *** logic/bccs_map.vh ***
// Purpose: constants for the boot configuration clock select block
// Assumes: 32-bit apb, word aligned registers
// Notes: offsets of the register window are local choices
`ifndef BCCS_MAP_VH
`define BCCS_MAP_VH
`define BCCS_OFF_WORD0 12'h000
`define BCCS_OFF_WORD1 12'h004
`define BCCS_OFF_STATUS 12'h008
`define BCCS_OFF_LOAD0 12'h00c
`define BCCS_OFF_LOAD1 12'h010
`define BCCS_OFF_CTRL 12'h014
`define BCCS_ERASED 32'hffffffff
`define BCCS_W0_RSV_ONES 32'h6effffff
`define BCCS_W0_RSV_MASK 32'heef003e0
`define BCCS_W0_CP 28
`define BCCS_W0_BWP 24
`define BCCS_W0_DBG_EN 2
`define BCCS_W1_CKSM_HI 15
`define BCCS_W1_CKSM_LO 14
`define BCCS_W1_PBDIV_HI 13
`define BCCS_W1_PBDIV_LO 12
`define BCCS_W1_CLOCK_OUTPUT_CFG 10
`define BCCS_W1_POSC_HI 9
`define BCCS_W1_POSC_LO 8
`define BCCS_W1_TWO_SPEED_SWITCHOVER 7
`define BCCS_W1_SOSC_EN 5
`define BCCS_W1_NOSC_HI 2
`define BCCS_W1_NOSC_LO 0
`define BCCS_W1_RSV_MASK 32'h00000858
`define BCCS_POSC_EC 2'h0
`define BCCS_POSC_XT 2'h1
`define BCCS_POSC_HS 2'h2
`define BCCS_POSC_OFF 2'h3
`define BCCS_NOSC_FRC 3'h0
`define BCCS_NOSC_FAST_INTERNAL_OSC_DIVIDED_PLL 3'h1
`define BCCS_NOSC_POSC 3'h2
`define BCCS_NOSC_POSC_PLL 3'h3
`define BCCS_NOSC_SOSC 3'h4
`define BCCS_NOSC_LOW_POWER_INTERNAL_OSC 3'h5
`define BCCS_NOSC_FAST_INTERNAL_OSC_DIV16 3'h6
`define BCCS_NOSC_FAST_INTERNAL_OSC_DIVIDED 3'h7
`define BCCS_CTRL_RELEASE 0
`define BCCS_CTRL_LOAD 1
`endif

// *** logic/bccs_top.v ***
// Purpose: capture and decode of the two boot configuration words
// Assumes: nonvolatile words arrive on nv_word0/nv_word1 ports, apb slave
// Notes: words latch once after reset release, then stay read-only
// Functional notes
// - code_protect low refuses external programmer reads and writes of flash.
// - boot_write_protect low blocks boot flash writes during execution.
// - debug_port_enable in word0 seeds the runtime_config_control debug enable.
// - clock_switch_monitor_sel 1x disables both, 01 switching only, 00 both.
// - periph_bus_divisor_default codes 00..11 divide system_clock by 1, 2, 4, 8.
// - clock_out_config low drives clock_output on osc_output_pin if primary mode is 11 or 00.
// - primary_osc_mode 11 off, 10 high speed crystal, 01 standard crystal, 00 external clock.
// - two_speed_switchover high runs from the internal oscillator until a primary source (010 or 011) is ready.
// - secondary_osc_enable high turns the secondary oscillator on.
// - osc_source_select 111 divided fast, 110 div16 fast, 101 low power, 100 secondary.
// - osc_source_select 011 primary with loop, 010 primary, 001 divided fast with loop, 000 fast.
`include "bccs_map.vh"
`default_nettype none
module bccs_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    input wire [31:0] nv_word0,
    input wire [31:0] nv_word1,
    input wire prog_read_req,
    input wire prog_write_req,
    input wire cpu_boot_write_req,
    input wire osc_source_ready,
    output wire prog_read_grant,
    output wire prog_write_grant,
    output wire boot_write_grant,
    output wire debug_port_enable,
    output wire clock_switch_enable,
    output wire fail_safe_monitor_enable,
    output wire [3:0] periph_bus_divisor,
    output wire [1:0] primary_osc_mode,
    output wire primary_osc_enable,
    output wire high_speed_crystal_mode,
    output wire standard_crystal_mode,
    output wire external_clock_mode,
    output wire clock_output_enable,
    output wire secondary_osc_enable,
    output wire [7:0] osc_source_onehot,
    output wire pll_enable,
    output wire running_on_internal,
    output wire cpu_fetch_enable
);
    localparam ST_LOAD = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_RUN = 3'b100;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [31:0] word0_ff;
    reg [31:0] word1_ff;
    reg loaded_ff;
    reg two_speed_switchover_hold_ff;
    reg nxt_two_speed_switchover_hold;
    reg soft_release_ff;

    wire cp_bit = word0_ff[`BCCS_W0_CP];
    wire bwp_bit = word0_ff[`BCCS_W0_BWP];
    wire [1:0] cksm = word1_ff[`BCCS_W1_CKSM_HI:`BCCS_W1_CKSM_LO];
    wire [1:0] pbdiv = word1_ff[`BCCS_W1_PBDIV_HI:`BCCS_W1_PBDIV_LO];
    wire [2:0] nosc = word1_ff[`BCCS_W1_NOSC_HI:`BCCS_W1_NOSC_LO];
    wire w0_rsv_ok = ((word0_ff ^ `BCCS_W0_RSV_ONES) & `BCCS_W0_RSV_MASK) == 32'h0;
    wire w1_rsv_ok = (word1_ff & `BCCS_W1_RSV_MASK) == `BCCS_W1_RSV_MASK;
    wire combo_bad = (nosc == `BCCS_NOSC_POSC) && (primary_osc_mode == `BCCS_POSC_OFF);
    wire uses_primary = (nosc == `BCCS_NOSC_POSC) || (nosc == `BCCS_NOSC_POSC_PLL);

    // capture sequence: load words, optional two-speed wait, then run
    always @*
    begin
        nxt_state = state_ff;
        nxt_two_speed_switchover_hold = two_speed_switchover_hold_ff;
        case (state_ff)
            ST_LOAD:
            begin
                nxt_state = ST_WAIT;
                nxt_two_speed_switchover_hold = 1'b1;
            end
            ST_WAIT:
            begin
                if (!word1_ff[`BCCS_W1_TWO_SPEED_SWITCHOVER] || !uses_primary || osc_source_ready)
                begin
                    nxt_state = ST_RUN;
                    nxt_two_speed_switchover_hold = 1'b0;
                end
            end
            ST_RUN:
            begin
                nxt_state = ST_RUN;
                nxt_two_speed_switchover_hold = 1'b0;
            end
            default:
            begin
                nxt_state = ST_LOAD;
                nxt_two_speed_switchover_hold = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_LOAD;
            two_speed_switchover_hold_ff <= 1'b0;
            loaded_ff <= 1'b0;
            word0_ff <= `BCCS_ERASED;
            word1_ff <= `BCCS_ERASED;
        end
        else
        begin
            state_ff <= nxt_state;
            two_speed_switchover_hold_ff <= nxt_two_speed_switchover_hold;
            if (state_ff == ST_LOAD)
            begin
                word0_ff <= nv_word0;
                word1_ff <= nv_word1;
                loaded_ff <= 1'b1;
            end
        end
    end

    // apb: zero wait, writes only to the release control bit
    wire apb_access = psel && penable;
    wire addr_ok = (paddr == `BCCS_OFF_WORD0) || (paddr == `BCCS_OFF_WORD1) ||
                   (paddr == `BCCS_OFF_STATUS) || (paddr == `BCCS_OFF_LOAD0) ||
                   (paddr == `BCCS_OFF_LOAD1) || (paddr == `BCCS_OFF_CTRL);
    wire ro_hit = (paddr != `BCCS_OFF_CTRL);
    assign pready = 1'b1;
    assign pslverr = apb_access && (!addr_ok || (pwrite && ro_hit));

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            soft_release_ff <= 1'b1;
        else if (apb_access && pwrite && paddr == `BCCS_OFF_CTRL)
            soft_release_ff <= pwdata[`BCCS_CTRL_RELEASE];
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `BCCS_OFF_WORD0: prdata <= word0_ff;
                `BCCS_OFF_WORD1: prdata <= word1_ff;
                `BCCS_OFF_STATUS: prdata <= {24'h0, state_ff, combo_bad,
                                            w1_rsv_ok, w0_rsv_ok, two_speed_switchover_hold_ff, loaded_ff};
                `BCCS_OFF_LOAD0: prdata <= nv_word0;
                `BCCS_OFF_LOAD1: prdata <= nv_word1;
                `BCCS_OFF_CTRL: prdata <= {30'h0, loaded_ff, soft_release_ff};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // decoded settings from captured words, grants gated by live requests
    assign prog_read_grant = prog_read_req && cp_bit;
    assign prog_write_grant = prog_write_req && cp_bit;
    assign boot_write_grant = cpu_boot_write_req && bwp_bit;
    assign debug_port_enable = word0_ff[`BCCS_W0_DBG_EN];
    assign clock_switch_enable = !cksm[1];
    assign fail_safe_monitor_enable = (cksm == 2'h0);
    assign periph_bus_divisor = 4'h1 << pbdiv;
    assign primary_osc_mode = word1_ff[`BCCS_W1_POSC_HI:`BCCS_W1_POSC_LO];
    assign primary_osc_enable = (primary_osc_mode != `BCCS_POSC_OFF);
    assign high_speed_crystal_mode = (primary_osc_mode == `BCCS_POSC_HS);
    assign standard_crystal_mode = (primary_osc_mode == `BCCS_POSC_XT);
    assign external_clock_mode = (primary_osc_mode == `BCCS_POSC_EC);
    assign clock_output_enable = !word1_ff[`BCCS_W1_CLOCK_OUTPUT_CFG] &&
        (primary_osc_mode == `BCCS_POSC_OFF || primary_osc_mode == `BCCS_POSC_EC);
    assign secondary_osc_enable = word1_ff[`BCCS_W1_SOSC_EN] ||
        (nosc == `BCCS_NOSC_SOSC);
    assign osc_source_onehot = 8'h01 << nosc;
    assign pll_enable = (nosc == `BCCS_NOSC_POSC_PLL) ||
        (nosc == `BCCS_NOSC_FAST_INTERNAL_OSC_DIVIDED_PLL);
    assign running_on_internal = two_speed_switchover_hold_ff;
    assign cpu_fetch_enable = (state_ff == ST_RUN) && soft_release_ff;
endmodule
`default_nettype wire

// *** tb/bccs_properties.sv ***
// Purpose: port checks for bccs_top
// Assumes: words captured at first edge after reset release
// Notes: keeps its own copy of the captured words
`default_nettype none
module bccs_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] nv_word0,
    input wire logic [31:0] nv_word1,
    input wire logic prog_read_req,
    input wire logic cpu_boot_write_req,
    input wire logic prog_read_grant,
    input wire logic boot_write_grant,
    input wire logic debug_port_enable,
    input wire logic clock_switch_enable,
    input wire logic fail_safe_monitor_enable,
    input wire logic [3:0] periph_bus_divisor,
    input wire logic clock_output_enable,
    input wire logic secondary_osc_enable,
    input wire logic [7:0] osc_source_onehot,
    input wire logic running_on_internal
);
    logic [31:0] w0_ff;
    logic [31:0] w1_ff;
    logic got_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            w0_ff <= 32'hffffffff;
            w1_ff <= 32'hffffffff;
            got_ff <= 1'h0;
        end
        else if (!got_ff)
        begin
            w0_ff <= nv_word0;
            w1_ff <= nv_word1;
            got_ff <= 1'h1;
        end
    end
    a_read_grant: assert property (prog_read_grant == (prog_read_req & w0_ff[28]))
        else $error("read grant wrong");
    a_boot_write: assert property (boot_write_grant == (cpu_boot_write_req & w0_ff[24]))
        else $error("boot write grant wrong");
    a_debug_seed: assert property (debug_port_enable == w0_ff[2])
        else $error("debug enable wrong");
    a_switch_monitor: assert property (clock_switch_enable == !w1_ff[15]
        && fail_safe_monitor_enable == (w1_ff[15:14] == 2'h0)) else $error("switch wrong");
    a_bus_divisor: assert property (periph_bus_divisor == (4'h1 << w1_ff[13:12]))
        else $error("divisor wrong");
    a_clock_out: assert property (clock_output_enable == (!w1_ff[10]
        && w1_ff[9] == w1_ff[8])) else $error("clock output wrong");
    a_sec_osc: assert property (secondary_osc_enable == (w1_ff[5]
        || w1_ff[2:0] == 3'h4)) else $error("secondary enable wrong");
    a_source_onehot: assert property (osc_source_onehot == (8'h1 << w1_ff[2:0]))
        else $error("source select wrong");
    a_two_speed: assert property (running_on_internal && !w1_ff[7] |=> !running_on_internal)
        else $error("two-speed hold wrong");
    cover property (running_on_internal ##1 running_on_internal);
    cover property (prog_read_grant);
    cover property (clock_output_enable);
endmodule
bind bccs_top bccs_props u_props (.*);
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for bccs_top
// Assumes: zero-wait apb slave, words captured after reset
// Notes: legal random words, one reset per pass
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, prog_read_req, prog_write_req;
    logic cpu_boot_write_req, osc_source_ready, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, nv_word0, nv_word1, q;
    wire pready, pslverr, prog_read_grant, prog_write_grant, boot_write_grant;
    wire debug_port_enable, clock_switch_enable, fail_safe_monitor_enable;
    wire primary_osc_enable, high_speed_crystal_mode, standard_crystal_mode;
    wire external_clock_mode, clock_output_enable, secondary_osc_enable;
    wire pll_enable, running_on_internal, cpu_fetch_enable;
    wire [31:0] prdata;
    wire [3:0] periph_bus_divisor;
    wire [1:0] primary_osc_mode;
    wire [7:0] osc_source_onehot;
    int mismatches, compares;
    bccs_top uut (.*);
    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #200us;
        mismatches++;
        give_verdict();
    end
    initial
    begin
        logic [31:0] w0, w1;
        {psel, penable, pwrite, paddr, pwdata, nv_word0, nv_word1} = '0;
        {prog_read_req, prog_write_req, cpu_boot_write_req, osc_source_ready} = '0;
        presetn = 1'h0;
        void'($urandom(32'h92e3));
        for (int k = 0; k < 16; k++)
        begin
            // legal words: reserved bits set, primary never off when 010 selected, but off with 011 for k 3 and 11
            w0 = ($urandom & 32'h110ffc1f) | 32'h6ef003e0;
            w1 = ($urandom & 32'hf420) | 32'hffff0858 | (k % 8) | ((k % 4) << 8) | ((k / 8) << 7);
            osc_source_ready <= 1'h0;
            presetn <= 1'h0;
            repeat (4) @(posedge pclk);
            nv_word0 <= w0;
            nv_word1 <= w1;
            presetn <= 1'h1;
            repeat (6) @(posedge pclk);
            chk(running_on_internal, w1[7] && w1[2:1] == 2'h1);
            osc_source_ready <= 1'h1;
            repeat (3) @(posedge pclk);
            chk(running_on_internal, 0);
            chk(cpu_fetch_enable, 1);
            apb(0, 12'h000, 0);
            chk(q, w0);
            apb(0, 12'h004, 0);
            chk(q, w1);
            apb(1, 12'h000, $urandom);
            chk(e, 1);
            apb(0, 12'h000, 0);
            chk(q, w0);
            apb(0, 12'h100, 0);
            chk(e, 1);
            chk(q, 0);
            apb(0, 12'h008, 0);
            chk(q, 32'h0000008d);
            apb(1, 12'h014, 0);
            {prog_read_req, prog_write_req, cpu_boot_write_req} <= 3'($urandom);
            @(posedge pclk);
            chk(cpu_fetch_enable, 0);
            chk(prog_read_grant, prog_read_req & w0[28]);
            chk(prog_write_grant, prog_write_req & w0[28]);
            chk(boot_write_grant, cpu_boot_write_req & w0[24]);
            chk(periph_bus_divisor, 4'h1 << w1[13:12]);
            chk(primary_osc_mode, w1[9:8]);
            chk(debug_port_enable, w0[2]);
            chk({clock_switch_enable, fail_safe_monitor_enable}, {!w1[15], w1[15:14] == 2'h0});
            chk(clock_output_enable, !w1[10] && w1[9] == w1[8]);
            chk({primary_osc_enable, high_speed_crystal_mode, standard_crystal_mode, external_clock_mode},
                {w1[9:8] != 2'h3, w1[9:8] == 2'h2, w1[9:8] == 2'h1, w1[9:8] == 2'h0});
            chk(secondary_osc_enable, w1[5] || w1[2:0] == 3'h4);
            chk(pll_enable, w1[2:0] == 3'h3 || w1[2:0] == 3'h1);
            chk(osc_source_onehot, 8'h1 << w1[2:0]);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
